//--- cac_pkg.sv
// Shared constants and types for the current converter control block
package cac_pkg;

   // Setup register: width, reset value and field layout
   localparam int          SETUP_BITS     = 12;
   localparam logic [11:0] SETUP_RESET    = 12'h0F00;
   localparam logic [3:0]  SETUP_LAST_BIT = 4'hB;

   typedef struct packed {
      logic [2:0] range_code;   // Bits 11..9, full-scale range
      logic       wide_words;   // Bit 8, 1 = 20-bit words
      logic       fast_grade;   // Bit 7, speed grade
      logic       quarter_div;  // Bit 6, system clock divide by 4
      logic [4:0] must_be_zero; // Bits 5..1
      logic       zero_test;    // Bit 0, inputs disconnected
   } cac_setup_t;

   // Result word widths
   localparam int WORD_WIDE   = 20;
   localparam int WORD_NARROW = 16;

   // Internal clock divider
   localparam logic [1:0] DIV_LAST = 2'h3;

   // Timing in internal clock periods
   localparam int          CMDR_PERIODS       = 1382;
   localparam int          MRAZ_LOW_PERIODS   = 1552;
   localparam int          MRAZ_FAST_PERIODS  = 1612;
   localparam int          CNT_BITS           = 11;
   localparam logic [10:0] CONT_READY_DELAY   = CNT_BITS'(CMDR_PERIODS);
   localparam logic [10:0] MRAZ_LOW_CYCLES    = CNT_BITS'(MRAZ_LOW_PERIODS);
   localparam logic [10:0] MRAZ_FAST_CYCLES   = CNT_BITS'(MRAZ_FAST_PERIODS);
   localparam logic [10:0] CNT_ZERO           = 11'h000;
   localparam logic [10:0] CNT_ONE            = 11'h001;

   // Pin synchroniser lanes
   localparam int PIN_LANES  = 6;
   localparam int LANE_RST_N = 0;
   localparam int LANE_TOG   = 1;
   localparam int LANE_RDCLK = 2;
   localparam int LANE_CHAIN = 3;
   localparam int LANE_CFGD  = 4;
   localparam int LANE_CFGC  = 5;

   // Integrate/measure controller states
   typedef enum logic [1:0] {
      ST_CONT    = 2'b00,
      ST_NCONT   = 2'b01,
      ST_PREPARE = 2'b10
   } cac_state_t;

endpackage

//--- cac_meas_engine.sv
// Integrate/measure sequencing and result-ready timing
`timescale 1ns/1ps
module cac_meas_engine
   import cac_pkg::*;
(
   input  wire logic   sys_clk,
   input  wire logic   rst,
   input  wire logic   tick,
   input  wire logic   toggle_change,
   input  wire logic   fast_grade,
   output logic        measure_busy,
   output logic        continuous_mode,
   output logic        results_done
);

   cac_state_t         state_ff;
   cac_state_t         nxt_state;
   logic [10:0]        busy_cnt_ff;
   logic [10:0]        nxt_busy_cnt;
   logic [10:0]        ready_cnt_ff;
   logic [10:0]        nxt_ready_cnt;
   logic               done_ff;
   logic               nxt_done;
   logic [10:0]        mraz_len;

   // Cycle length follows the speed grade the host wrote
   assign mraz_len = fast_grade ? MRAZ_FAST_CYCLES : MRAZ_LOW_CYCLES;

   // Next-state: counters run on internal ticks, toggles start cycles
   always_comb begin
      nxt_state     = state_ff;
      nxt_busy_cnt  = busy_cnt_ff;
      nxt_ready_cnt = ready_cnt_ff;
      nxt_done      = 1'b0;
      if (tick && busy_cnt_ff != CNT_ZERO) begin
         nxt_busy_cnt = busy_cnt_ff - CNT_ONE;
      end
      if (tick && ready_cnt_ff != CNT_ZERO) begin
         nxt_ready_cnt = ready_cnt_ff - CNT_ONE;
         nxt_done      = (ready_cnt_ff == CNT_ONE);
      end
      unique case (state_ff)
         ST_CONT: begin
            if (toggle_change) begin
               if (busy_cnt_ff != CNT_ZERO) begin
                  nxt_state = ST_NCONT;
               end else begin
                  nxt_busy_cnt  = mraz_len;
                  nxt_ready_cnt = CONT_READY_DELAY;
               end
            end
         end
         ST_NCONT: begin
            // Integration halted until digitising catches up
            if (busy_cnt_ff == CNT_ZERO) begin
               nxt_state = ST_PREPARE;
            end
         end
         ST_PREPARE: begin
            if (tick) begin
               nxt_state     = ST_CONT;
               nxt_busy_cnt  = mraz_len;
               nxt_ready_cnt = CONT_READY_DELAY;
            end
         end
         default: begin
            nxt_state = ST_NCONT;
         end
      endcase
   end

   // Registers; power-up sits in the noncontinuous state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_ff     <= ST_NCONT;
         busy_cnt_ff  <= CNT_ZERO;
         ready_cnt_ff <= CNT_ZERO;
         done_ff      <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         busy_cnt_ff  <= nxt_busy_cnt;
         ready_cnt_ff <= nxt_ready_cnt;
         done_ff      <= nxt_done;
      end
   end

   assign measure_busy    = (busy_cnt_ff != CNT_ZERO);
   assign continuous_mode = (state_ff == ST_CONT);
   assign results_done    = done_ff;

endmodule

//--- cac_top.sv
// Setup register, result readout port and converter timing control
`timescale 1ns/1ps
//
// Overview of operation
// - Bits 11..9 select full-scale range, default 111
// - Bit 8 selects 16 or 20 bit words
// - Bit 6 divides system clock by four
// - Bit 0 disconnects inputs for zero test
// - Readout runs independently of conversion timing
// - Ready flag low when results available
// - Ready flag timed from free-running divided clock
// - Low reset input resets the device
// - Each cycle digitises and resets integrators
// - Idle converter at toggle means continuous mode
// - Busy converter at toggle means noncontinuous mode
// - Setup reached only via configuration pins
// - Twelve bits, MSB first, falling clock edge
// - Ready stays low until readout clock pulses
// - Ready falls 1382 periods after toggle in continuous mode
module cac_top
   import cac_pkg::*;
#(
   parameter int CHANNELS = 32
)
(
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   input  wire logic                           device_reset_n,
   input  wire logic                           integrate_side_toggle,
   input  wire logic                           readout_shift_clock,
   input  wire logic                           chain_data_in,
   input  wire logic                           setup_data_in,
   input  wire logic                           setup_shift_clock,
   input  wire logic [CHANNELS*WORD_WIDE-1:0]  integrate_side_toggle_results,
   output logic                                result_ready_n,
   output logic                                serial_data_out,
   output logic [2:0]                          range_select,
   output logic                                wide_words,
   output logic                                fast_grade,
   output logic                                inputs_disconnect,
   output logic                                internal_tick,
   output logic                                continuous_mode,
   output logic                                measure_busy
);

   localparam int FRAME = CHANNELS * WORD_WIDE;

   logic [PIN_LANES-1:0]  sync_a_ff;
   logic [PIN_LANES-1:0]  sync_b_ff;
   logic [PIN_LANES-1:0]  prev_ff;
   logic                  dev_rst;
   logic                  tog_change;
   logic                  rd_rise;
   logic                  rd_fall;
   logic                  cfg_fall;
   logic [1:0]            div_ff;
   logic [1:0]            nxt_div;
   logic                  tick;
   cac_setup_t            setup_ff;
   cac_setup_t            nxt_setup;
   logic [11:0]           cfg_shift_ff;
   logic [11:0]           nxt_cfg_shift;
   logic [3:0]            cfg_count_ff;
   logic [3:0]            nxt_cfg_count;
   logic [FRAME-1:0]      frame_ff;
   logic [FRAME-1:0]      nxt_frame;
   logic [FRAME-1:0]      frame_narrow;
   logic                  ready_n_ff;
   logic                  nxt_ready_n;
   logic                  seen_high_ff;
   logic                  nxt_seen_high;
   logic                  results_done;

   // Two-stage synchronisers on every pin input
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync_a_ff <= '0;
         sync_b_ff <= '0;
         prev_ff   <= '0;
      end else begin
         sync_a_ff <= {setup_shift_clock, setup_data_in, chain_data_in,
                       readout_shift_clock, integrate_side_toggle, device_reset_n};
         sync_b_ff <= sync_a_ff;
         prev_ff   <= sync_b_ff;
      end
   end

   // Device reset held while pin is low; pin is asynchronous to us
   assign dev_rst    = rst | ~sync_b_ff[LANE_RST_N];
   assign tog_change = sync_b_ff[LANE_TOG] ^ prev_ff[LANE_TOG];
   assign rd_rise    = sync_b_ff[LANE_RDCLK] & ~prev_ff[LANE_RDCLK];
   assign rd_fall    = ~sync_b_ff[LANE_RDCLK] & prev_ff[LANE_RDCLK];
   assign cfg_fall   = ~sync_b_ff[LANE_CFGC] & prev_ff[LANE_CFGC];

   // Divider phase survives device reset, so its phase to the toggle is arbitrary
   always_comb begin
      nxt_div = div_ff + 2'h1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_ff <= '0;
      end else begin
         div_ff <= nxt_div;
      end
   end

   assign tick = setup_ff.quarter_div ? (div_ff == DIV_LAST) : 1'b1;

   // Setup shift: bits taken on falling shift clock, committed after all twelve
   always_comb begin
      nxt_setup     = setup_ff;
      nxt_cfg_shift = cfg_shift_ff;
      nxt_cfg_count = cfg_count_ff;
      if (cfg_fall && cfg_count_ff <= SETUP_LAST_BIT) begin
         nxt_cfg_shift = {cfg_shift_ff[10:0], sync_b_ff[LANE_CFGD]};
         nxt_cfg_count = cfg_count_ff + 4'h1;
         // Partial writes never reach the live setup
         if (cfg_count_ff == SETUP_LAST_BIT) begin
            nxt_setup = cac_setup_t'({cfg_shift_ff[10:0], sync_b_ff[LANE_CFGD]});
         end
      end
   end

   // Count restarts on each device reset; setup keeps its value across it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         setup_ff     <= cac_setup_t'(SETUP_RESET);
         cfg_shift_ff <= '0;
         cfg_count_ff <= '0;
      end else if (dev_rst) begin
         setup_ff     <= setup_ff;
         cfg_shift_ff <= '0;
         cfg_count_ff <= '0;
      end else begin
         setup_ff     <= nxt_setup;
         cfg_shift_ff <= nxt_cfg_shift;
         cfg_count_ff <= nxt_cfg_count;
      end
   end

   assign range_select      = setup_ff.range_code;
   assign wide_words        = setup_ff.wide_words;
   assign fast_grade        = setup_ff.fast_grade;
   assign inputs_disconnect = setup_ff.zero_test;
   assign internal_tick     = tick;

   cac_meas_engine u_engine (
      .sys_clk         (sys_clk),
      .rst             (dev_rst),
      .tick            (tick),
      .toggle_change   (tog_change),
      .fast_grade      (setup_ff.fast_grade),
      .measure_busy    (measure_busy),
      .continuous_mode (continuous_mode),
      .results_done    (results_done)
   );

   // Narrow frame: top 16 bits of each word, channel 0 sent first
   genvar gi;
   generate
      for (gi = 0; gi < CHANNELS; gi++) begin : g_pack
         assign frame_narrow[FRAME-1-gi*WORD_NARROW -: WORD_NARROW] =
            integrate_side_toggle_results[gi*WORD_WIDE+WORD_WIDE-1 -: WORD_NARROW];
      end
      assign frame_narrow[FRAME-CHANNELS*WORD_NARROW-1:0] = '0;
   endgenerate

   // Readout: load on results, shift on readout clock rise, chain fills behind
   always_comb begin
      nxt_frame     = frame_ff;
      nxt_ready_n   = ready_n_ff;
      nxt_seen_high = seen_high_ff;
      if (rd_rise) begin
         nxt_frame = {frame_ff[FRAME-2:0], sync_b_ff[LANE_CHAIN]};
         if (!ready_n_ff) begin
            nxt_seen_high = 1'b1;
         end
      end
      if (rd_fall && seen_high_ff) begin
         nxt_ready_n   = 1'b1;
         nxt_seen_high = 1'b0;
      end
      // New results win over a clearing pulse in the same cycle
      if (results_done) begin
         nxt_frame     = setup_ff.wide_words ? integrate_side_toggle_results : frame_narrow;
         nxt_ready_n   = 1'b0;
         nxt_seen_high = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (dev_rst) begin
         frame_ff     <= '0;
         ready_n_ff   <= 1'b1;
         seen_high_ff <= 1'b0;
      end else begin
         frame_ff     <= nxt_frame;
         ready_n_ff   <= nxt_ready_n;
         seen_high_ff <= nxt_seen_high;
      end
   end

   assign result_ready_n  = ready_n_ff;
   assign serial_data_out = frame_ff[FRAME-1];

endmodule

//--- cac_top_properties.sv
// Port checks for the converter control block
`timescale 1ns/1ps
module cac_top_properties
   import cac_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       device_reset_n,
   input wire logic       integrate_side_toggle,
   input wire logic       readout_shift_clock,
   input wire logic       result_ready_n,
   input wire logic [2:0] range_select,
   input wire logic       wide_words,
   input wire logic       fast_grade,
   input wire logic       inputs_disconnect,
   input wire logic       internal_tick,
   input wire logic       continuous_mode,
   input wire logic       measure_busy
);
   logic        tog_ff, tick_ff, arm_ff, seen_ff, nxt_arm, nxt_seen;
   logic [11:0] cnt_ff, nxt_cnt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Delay counter armed by a toggle at full tick rate; a device reset disarms it
   always_comb begin
      nxt_cnt = cnt_ff + 12'h001;
      nxt_arm = arm_ff && result_ready_n && device_reset_n;
      if (tog_ff != integrate_side_toggle && continuous_mode && !measure_busy
          && tick_ff && internal_tick) begin
         nxt_arm = 1'b1;
         nxt_cnt = 12'h000;
      end
      nxt_seen = (seen_ff || readout_shift_clock || !device_reset_n) && !result_ready_n;
   end
   // History registers
   always_ff @(posedge sys_clk) begin
      tog_ff  <= integrate_side_toggle;
      tick_ff <= internal_tick;
      arm_ff  <= nxt_arm && !rst;
      seen_ff <= nxt_seen && !rst;
      cnt_ff  <= nxt_cnt;
   end
   // Reset checks must not be masked by the reset itself
   a_setup_defaults: assert property (disable iff (1'b0)
      rst |=> range_select == 3'h7 && wide_words && !fast_grade && !inputs_disconnect)
      else $error("setup fields not at default after reset");
   a_ready_reset: assert property (disable iff (1'b0) rst |=> result_ready_n)
      else $error("ready flag low after reset");
   a_quarter_tick: assert property ($rose(internal_tick) ##1 !internal_tick
      |-> !internal_tick [*3] ##1 internal_tick) else $error("tick not one in four");
   a_ready_late: assert property (arm_ff |-> cnt_ff <= 12'h570)
      else $error("ready flag too late after toggle");
   a_ready_early: assert property (arm_ff && !result_ready_n |-> cnt_ff >= 12'h562)
      else $error("ready flag too early after toggle");
   a_busy_start: assert property ($changed(integrate_side_toggle) && !measure_busy
      && tick_ff && internal_tick |-> ##[1:8] measure_busy) else $error("no cycle started");
   a_ncont_entry: assert property ($changed(integrate_side_toggle) && measure_busy
      ##1 measure_busy [*3] |-> ##[0:4] !continuous_mode) else $error("busy toggle kept cont");
   a_cont_hold: assert property ($changed(integrate_side_toggle) && continuous_mode
      && !measure_busy |-> continuous_mode [*6]) else $error("idle toggle left cont");
   a_ready_hold: assert property ($rose(result_ready_n) |-> seen_ff)
      else $error("ready flag rose without readout pulse");
   c_ready: cover property ($fell(result_ready_n));
   c_ncont: cover property (measure_busy && !continuous_mode);
   c_quarter: cover property ($fell(internal_tick));
endmodule

//--- cac_host_model.sv
// Host model: setup writes, conversion toggle and result readout
`timescale 1ns/1ps
module cac_host_model (
   input  wire logic        sys_clk,
   input  wire logic        serial_data_out,
   input  wire logic        result_ready_n,
   output logic             device_reset_n,
   output logic             integrate_side_toggle,
   output logic             readout_shift_clock,
   output logic             setup_data_in,
   output logic             setup_shift_clock,
   output logic [39:0]      frame,
   output logic             frame_done
);
   // Idle pin levels
   initial begin
      device_reset_n = 1'b1;
      {integrate_side_toggle, readout_shift_clock, setup_data_in} = 3'h0;
      {setup_shift_clock, frame_done} = 2'h0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Toggle low, reset pulse of over 1 us, then bits MSB first
   task automatic setup(input logic [11:0] v, input int nb);
      w(1);
      integrate_side_toggle <= 1'b0;
      w(10);
      device_reset_n <= 1'b0;
      w(260);
      device_reset_n <= 1'b1;
      w(20);
      for (int i = 11; i > 11 - nb; i--) begin
         setup_data_in <= v[i];
         w(6);
         setup_shift_clock <= 1'b1;
         w(6);
         setup_shift_clock <= 1'b0;
         w(6);
         setup_data_in <= ~v[i]; // Stale level never repeats
         w(3);
      end
      w(20);
   endtask
   // Edge-aligned flip while readout clock rests low
   task automatic flip();
      w(1);
      integrate_side_toggle <= ~integrate_side_toggle;
   endtask
   // Poll ready, then shift at a pace unrelated to conversion
   task automatic read();
      for (int i = 0; i < 1600 && result_ready_n !== 1'b0; i++) w(10);
      w(4);
      for (int i = 39; i >= 0; i--) begin
         frame[i] = serial_data_out;
         readout_shift_clock <= 1'b1;
         w(6);
         readout_shift_clock <= 1'b0;
         w(6);
      end
      frame_done <= 1'b1;
      w(1);
      frame_done <= 1'b0;
   endtask
endmodule

//--- test_current_adc_config_and_readout.sv
// Testbench for the converter control block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_current_adc_config_and_readout;
   import cac_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        chain_data_in = 1'b0;
   logic [39:0] integrate_side_toggle_results = '0;
   logic [31:0] lf = 32'h0001_7165;
   logic [39:0] expq[$];
   int          errors = 0;
   int          comparisons = 0;
   logic        device_reset_n, integrate_side_toggle, readout_shift_clock;
   logic        setup_data_in, setup_shift_clock, result_ready_n, serial_data_out;
   logic [2:0]  range_select;
   logic        wide_words, fast_grade, inputs_disconnect, internal_tick;
   logic        continuous_mode, measure_busy, frame_done;
   logic [39:0] frame, e;
   logic [11:0] v;
   always #2 sys_clk = ~sys_clk;
   cac_top #(.CHANNELS(2)) i_dut (.sys_clk, .rst, .device_reset_n, .integrate_side_toggle,
      .readout_shift_clock, .chain_data_in, .setup_data_in, .setup_shift_clock, .integrate_side_toggle_results,
      .result_ready_n, .serial_data_out, .range_select, .wide_words, .fast_grade,
      .inputs_disconnect, .internal_tick, .continuous_mode, .measure_busy);
   cac_host_model i_host (.sys_clk, .serial_data_out, .result_ready_n, .device_reset_n,
      .integrate_side_toggle, .readout_shift_clock, .setup_data_in, .setup_shift_clock,
      .frame, .frame_done);
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Narrow frames carry the top 16 bits of each channel, channel 0 first
   function automatic logic [39:0] fr(input logic [39:0] r, input logic wd);
      return wd ? r : {r[19:4], r[39:24], 8'h00};
   endfunction
   task automatic chk_setup(input logic [11:0] s);
      `CHK(range_select, s[11:9])
      `CHK(wide_words, s[8])
      `CHK(fast_grade, s[7])
      `CHK(inputs_disconnect, s[0])
   endtask
   // Fresh random results, noted before the readout that returns them
   task automatic measure(input logic wd);
      logic [39:0] r;
      @(posedge sys_clk);
      lf = nx(nx(lf));
      r = {lf, lf[31:24] ^ lf[7:0]};
      integrate_side_toggle_results <= r;
      expq.push_back(fr(r, wd));
      i_host.read();
      i_host.w(200);
   endtask
   task automatic report_and_stop();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Each finished frame against the oldest note
   always @(posedge sys_clk) begin
      if (frame_done === 1'b1) begin
         e = expq.pop_front();
         `CHK(frame, e)
      end
   end
   // Watchdog well past the expected run length
   initial begin
      #400000;
      errors++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      i_host.w(4);
      chk_setup(SETUP_RESET);
      for (int k = 0; k < 8; k++) begin
         v = {k[2:0], k[0], 2'b00, 5'h00, k[1]};
         i_host.setup(v, 12);
         chk_setup(v);
      end
      i_host.setup(12'h0000, 6);
      chk_setup(v);
      $display("setup tests done");
      for (int k = 0; k < 2; k++) begin
         i_host.flip();
         measure(v[8]);
      end
      // Read the cycle queued behind the halt; early results are only trusted as a model check
      measure(v[8]);
      // Toggle only once the converter is idle, so the cycle starts in continuous mode
      for (int i = 0; i < 2000 && measure_busy !== 1'b0; i++) i_host.w(1);
      `CHK(measure_busy, 1'b0)
      i_host.flip();
      measure(v[8]);
      `CHK(continuous_mode, 1'b1)
      i_host.flip();
      i_host.w(20);
      i_host.flip();
      i_host.w(10);
      `CHK(continuous_mode, 1'b0)
      measure(1'b1);
      measure(1'b1);
      $display("wide conversion tests done");
      v = 12'h0E80;
      i_host.setup(v, 12);
      chk_setup(v);
      for (int k = 0; k < 2; k++) begin
         i_host.flip();
         measure(1'b0);
      end
      $display("narrow conversion tests done");
      i_host.setup(12'h0F40, 12);
      i_host.flip();
      measure(1'b1);
      $display("divided clock test done");
      report_and_stop();
   end
endmodule
bind cac_top cac_top_properties i_props (.sys_clk, .rst, .device_reset_n,
   .integrate_side_toggle, .readout_shift_clock, .result_ready_n, .range_select, .wide_words,
   .fast_grade, .inputs_disconnect, .internal_tick, .continuous_mode, .measure_busy);
